// *** core/pwd_pkg.sv ***
// Purpose: Constants, register map and decode helpers for the PWM block.
// Assumes: One 50 MHz clock, byte wide register port.
// Notes:   Shared by the top module and the channel module.
// What this block does
// - Each channel keeps a 10-bit duty value in two byte registers.
// - Channel 2 high byte holds duty bits 9..2; low byte bits 1..0.
// - Duty zero keeps the output low for the whole period.
// - High time equals duty over 1024 of the period.
// - New duty is buffered and applied only at period end.
// - Channel n shares its pin with general port bit n.
// - Select bit routes PWM to pin and takes over the port driver.
// - Reset clears all four select bits, pins return to port use.
// - Inhibit bit forces all enabled channel outputs low.
// - Inhibit bit also halts the shared 10-bit counter.
// - Reset clears the inhibit bit so the counter runs.
// - Wait mode leaves the outputs running unchanged.
// - Stop mode with inhibit clear freezes each output level.
// - Stop mode with inhibit set drives enabled pins low.
// - After stop the interrupted period resumes, not restarts.
// - One period lasts 2048 processor clocks.
`default_nettype none
package pwd_pkg;
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 8;
   localparam int          DUTY_W         = 10;
   localparam int          NCH            = 4;
   localparam int          PERIOD_CLKS    = 2048;
   localparam int          CLKS_PER_STEP  = PERIOD_CLKS / (2 ** DUTY_W);
   localparam logic [9:0]  CNT_MAX        = 10'h3ff;
   localparam logic [9:0]  DUTY_RST       = 10'h000;
   localparam logic [7:0]  OFF_DUTY_BASE  = 8'h25;
   localparam logic [7:0]  OFF_DUTY_END   = 8'h2d;
   localparam logic [7:0]  OFF_DUTY_LO_CH1 = 8'h28;
   localparam logic [7:0]  OFF_DUTY_HI_CH2 = 8'h29;
   localparam logic [7:0]  OFF_PIN_SEL    = 8'h2d;
   localparam logic [7:0]  OFF_CNT_STAT   = 8'h2e;
   localparam int          SEL_LSB        = 0;
   localparam int          INH_BIT        = 7;
   localparam logic [3:0]  SEL_RST        = 4'h0;
   localparam logic        INH_RST        = 1'b0;
   localparam logic [7:0]  RD_ZERO        = 8'h00;

   // Register lies inside the duty window
   function automatic logic duty_hit(input logic [7:0] a);
      return (a >= OFF_DUTY_BASE) && (a < OFF_DUTY_END);
   endfunction

   // Offset inside the window: bits 2..1 channel, bit 0 low byte
   function automatic logic [2:0] duty_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - OFF_DUTY_BASE;
      return d[2:0];
   endfunction
endpackage
`default_nettype wire

// *** core/pwd_chan.sv ***
// Purpose: One modulator channel: active duty and compare output.
// Assumes: Counter and period strobe come from the top module.
// Notes:   Output is a flip-flop so the top sees a clean level.
`default_nettype none
module pwd_chan (
   // Clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rstn,
   // Shared timing
   input  wire logic [pwd_pkg::DUTY_W-1:0] cnt,
   input  wire logic                       period_end,
   input  wire logic                       inhibit,
   input  wire logic                       stop_mode,
   // Buffered duty from software
   input  wire logic [pwd_pkg::DUTY_W-1:0] duty_buf,
   // Results
   output logic      [pwd_pkg::DUTY_W-1:0] duty_act,
   output logic                            pwm
);
   typedef struct packed {
      logic [pwd_pkg::DUTY_W-1:0] act;
      logic                       out;
   } pwd_chan_s;

   pwd_chan_s st_ff;
   pwd_chan_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (period_end) begin
         nxt_st.act = duty_buf;
      end
      if (inhibit) begin
         nxt_st.out = 1'b0;
      end else if (stop_mode) begin
         nxt_st.out = st_ff.out;
      end else begin
         nxt_st.out = (cnt < st_ff.act);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '{act: pwd_pkg::DUTY_RST, out: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign duty_act = st_ff.act;
   assign pwm      = st_ff.out;
endmodule
`default_nettype wire

// *** core/pwd_top.sv ***
// Purpose: Four channel 10-bit PWM with shared port pins.
// Assumes: Byte register port, read data one cycle after strobe.
// Notes:   Stop mode input models the stopped oscillator.
`default_nettype none
module pwd_top (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rd_data,
   // Low power mode
   input  wire logic        stop_mode,
   // General port side of the shared pins
   input  wire logic [3:0]  gpio_out,
   input  wire logic [3:0]  gpio_oe,
   output logic      [3:0]  gpio_in,
   // Shared pins
   input  wire logic [3:0]  port_a_low_pins_in,
   output logic      [3:0]  port_a_low_pins_out,
   output logic      [3:0]  port_a_low_pins_oe
);
   localparam int NCH = pwd_pkg::NCH;
   localparam int DW  = pwd_pkg::DUTY_W;

   typedef struct packed {
      logic [NCH-1:0][DW-1:0] dbuf;
      logic [NCH-1:0]         sel;
      logic                   inh;
      logic                   div;
      logic [DW-1:0]          cnt;
      logic [7:0]             rdata;
      logic [NCH-1:0]         pin_out;
      logic [NCH-1:0]         pin_oe;
      logic [NCH-1:0]         pin_in;
   } pwd_top_s;

   pwd_top_s st_ff;
   pwd_top_s nxt_st;

   logic                   run;
   logic                   period_end;
   logic [NCH-1:0][DW-1:0] duty_act;
   logic [NCH-1:0]         chan_pwm;
   logic [2:0]             idx;
   logic [1:0]             ch;

   // Wait mode has no input here: the clock keeps running
   assign run        = !st_ff.inh && !stop_mode;
   assign period_end = run && st_ff.div &&
                       (st_ff.cnt == pwd_pkg::CNT_MAX);
   assign idx        = pwd_pkg::duty_idx(addr);
   assign ch         = idx[2:1];

   for (genvar n = 0; n < NCH; n++) begin : g_chan
      pwd_chan u_chan (
         .mclk       (mclk),
         .rstn       (rstn),
         .cnt        (st_ff.cnt),
         .period_end (period_end),
         .inhibit    (st_ff.inh),
         .stop_mode  (stop_mode),
         .duty_buf   (st_ff.dbuf[n]),
         .duty_act   (duty_act[n]),
         .pwm        (chan_pwm[n])
      );
   end

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rdata = pwd_pkg::RD_ZERO;

      // Divider and counter; stop or inhibit holds both in place
      if (run) begin
         nxt_st.div = !st_ff.div;
         if (st_ff.div) begin
            nxt_st.cnt = st_ff.cnt + 10'h001;
         end
      end

      // Writes land in the buffer only, never the active duty
      if (wr_en) begin
         if (pwd_pkg::duty_hit(addr)) begin
            if (idx[0]) begin
               nxt_st.dbuf[ch][1:0] = wr_data[1:0];
            end else begin
               nxt_st.dbuf[ch][9:2] = wr_data;
            end
         end else if (addr == pwd_pkg::OFF_PIN_SEL) begin
            nxt_st.sel = wr_data[pwd_pkg::SEL_LSB +: NCH];
            nxt_st.inh = wr_data[pwd_pkg::INH_BIT];
         end
      end

      // Read data stand in the single cycle after the strobe
      if (rd_en) begin
         if (pwd_pkg::duty_hit(addr)) begin
            if (idx[0]) begin
               nxt_st.rdata = {6'h00, st_ff.dbuf[ch][1:0]};
            end else begin
               nxt_st.rdata = st_ff.dbuf[ch][9:2];
            end
         end else if (addr == pwd_pkg::OFF_PIN_SEL) begin
            nxt_st.rdata = {st_ff.inh, 3'h0, st_ff.sel};
         end else if (addr == pwd_pkg::OFF_CNT_STAT) begin
            nxt_st.rdata = st_ff.cnt[9:2];
         end
      end

      // Pin mux; the port keeps its own bits when not selected
      for (int n = 0; n < NCH; n++) begin
         if (stop_mode) begin
            // Level frozen while stopped, except an inhibited pin
            if (st_ff.sel[n] && st_ff.inh) begin
               nxt_st.pin_out[n] = 1'b0;
            end
         end else if (st_ff.sel[n]) begin
            nxt_st.pin_out[n] = chan_pwm[n];
            nxt_st.pin_oe[n]  = 1'b1;
         end else begin
            nxt_st.pin_out[n] = gpio_out[n];
            nxt_st.pin_oe[n]  = gpio_oe[n];
         end
      end
      nxt_st.pin_in = port_a_low_pins_in;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_ff         <= '0;
         st_ff.sel     <= pwd_pkg::SEL_RST;
         st_ff.inh     <= pwd_pkg::INH_RST;
         st_ff.rdata   <= pwd_pkg::RD_ZERO;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data             = st_ff.rdata;
   assign gpio_in             = st_ff.pin_in;
   assign port_a_low_pins_out = st_ff.pin_out;
   assign port_a_low_pins_oe  = st_ff.pin_oe;

   // Checks, all in the single clock domain
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence s_write_hi2;
      wr_en && (addr == pwd_pkg::OFF_DUTY_HI_CH2);
   endsequence

   sequence s_write_lo1;
      wr_en && (addr == pwd_pkg::OFF_DUTY_LO_CH1);
   endsequence

   property p_hi2_map;
      logic [7:0] d;
      (s_write_hi2, d = wr_data) |=> (st_ff.dbuf[2][9:2] == d);
   endproperty
   a_hi2_map: assert property (p_hi2_map)
      else $error("High byte of channel 2 not stored");

   property p_lo1_map;
      logic [1:0] d;
      (s_write_lo1, d = wr_data[1:0]) |=> (st_ff.dbuf[1][1:0] == d);
   endproperty
   a_lo1_map: assert property (p_lo1_map)
      else $error("Low byte of channel 1 not stored");

   property p_zero_low;
      (duty_act[0] == 10'h000) && !stop_mode |=> !chan_pwm[0];
   endproperty
   a_zero_low: assert property (p_zero_low)
      else $error("Zero duty gave a high output");

   property p_below_high;
      !stop_mode && !st_ff.inh && (st_ff.cnt < duty_act[1])
         |=> chan_pwm[1];
   endproperty
   a_below_high: assert property (p_below_high)
      else $error("Output low while counter below duty");

   property p_act_at_end;
      $changed(duty_act[2]) |-> $past(period_end);
   endproperty
   a_act_at_end: assert property (p_act_at_end)
      else $error("Active duty changed inside a period");

   sequence s_sel_on;
      st_ff.sel[0] && !stop_mode;
   endsequence

   property p_sel_drive;
      s_sel_on |=> port_a_low_pins_oe[0] &&
                   (port_a_low_pins_out[0] == $past(chan_pwm[0]));
   endproperty
   a_sel_drive: assert property (p_sel_drive)
      else $error("Selected pin not driven by channel");

   property p_inh_low;
      st_ff.inh && st_ff.sel[3] ##1 st_ff.inh && st_ff.sel[3]
         |=> !port_a_low_pins_out[3];
   endproperty
   a_inh_low: assert property (p_inh_low)
      else $error("Inhibited pin not low");

   property p_inh_halt;
      st_ff.inh |=> $stable(st_ff.cnt);
   endproperty
   a_inh_halt: assert property (p_inh_halt)
      else $error("Counter moved while inhibited");

   property p_stop_freeze;
      stop_mode && !st_ff.inh |=> $stable(port_a_low_pins_out) &&
                                  $stable(st_ff.cnt);
   endproperty
   a_stop_freeze: assert property (p_stop_freeze)
      else $error("Pin or counter moved in stop mode");

   property p_step_two;
      run && st_ff.div ##1 run |=> $stable(st_ff.cnt);
   endproperty
   a_step_two: assert property (p_step_two)
      else $error("Counter stepped on consecutive clocks");

   property p_wrap;
      period_end |=> (st_ff.cnt == 10'h000);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Counter did not wrap at period end");

   // Reset checks run through reset itself, so no disable here
   property p_rst_sel;
      disable iff (1'b0)
      !rstn |=> (st_ff.sel == pwd_pkg::SEL_RST) &&
                (port_a_low_pins_oe == 4'h0);
   endproperty
   a_rst_sel: assert property (p_rst_sel)
      else $error("Select bits or pin enables not cleared by reset");

   property p_rst_inh;
      disable iff (1'b0)
      !rstn |=> (st_ff.inh == pwd_pkg::INH_RST) &&
                (rd_data == pwd_pkg::RD_ZERO);
   endproperty
   a_rst_inh: assert property (p_rst_inh)
      else $error("Inhibit bit not cleared by reset");

   property p_rd_idle;
      rstn && !rd_en |=> (rd_data == pwd_pkg::RD_ZERO);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("Read data stood longer than one cycle");

   property p_rd_status;
      rd_en && (addr == pwd_pkg::OFF_CNT_STAT)
         |=> (rd_data == $past(st_ff.cnt[9:2]));
   endproperty
   a_rd_status: assert property (p_rd_status)
      else $error("Counter status read wrong");

   property p_lo2_map;
      wr_en && (addr == (pwd_pkg::OFF_DUTY_HI_CH2 + 8'h01))
         |=> (st_ff.dbuf[2][1:0] == $past(wr_data[1:0]));
   endproperty
   a_lo2_map: assert property (p_lo2_map)
      else $error("Low byte of channel 2 not stored");

   property p_hi_keeps_lo;
      s_write_hi2 |=> $stable(st_ff.dbuf[2][1:0]);
   endproperty
   a_hi_keeps_lo: assert property (p_hi_keeps_lo)
      else $error("High byte write disturbed duty bits 1..0");

   sequence s_write_sel;
      wr_en && (addr == pwd_pkg::OFF_PIN_SEL);
   endsequence

   property p_sel_wr;
      s_write_sel |=> (st_ff.sel == $past(wr_data[3:0])) &&
                      (st_ff.inh == $past(wr_data[pwd_pkg::INH_BIT]));
   endproperty
   a_sel_wr: assert property (p_sel_wr)
      else $error("Pin select register not stored");

   property p_act_hold;
      !period_end |=> $stable(duty_act[0]);
   endproperty
   a_act_hold: assert property (p_act_hold)
      else $error("Channel 0 duty changed inside a period");

   property p_act_load;
      period_end |=> (duty_act[3] == $past(st_ff.dbuf[3]));
   endproperty
   a_act_load: assert property (p_act_load)
      else $error("Channel 3 duty not taken at period end");

   property p_full_high;
      (duty_act[2] == 10'h3ff) && !stop_mode && !st_ff.inh &&
      (st_ff.cnt != pwd_pkg::CNT_MAX) |=> chan_pwm[2];
   endproperty
   a_full_high: assert property (p_full_high)
      else $error("Largest duty gave a low output before the last step");

   property p_cnt_step;
      run && st_ff.div |=> (st_ff.cnt == $past(st_ff.cnt) + 10'h001);
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("Counter did not step by one");

   property p_div_hold;
      !run |=> $stable(st_ff.div);
   endproperty
   a_div_hold: assert property (p_div_hold)
      else $error("Divider moved while halted");

   property p_inh_chan_low;
      st_ff.inh |=> (chan_pwm == 4'h0);
   endproperty
   a_inh_chan_low: assert property (p_inh_chan_low)
      else $error("Channel output high while inhibited");

   property p_stop_inh_low;
      stop_mode && st_ff.inh
         |=> ((port_a_low_pins_out & $past(st_ff.sel)) == 4'h0);
   endproperty
   a_stop_inh_low: assert property (p_stop_inh_low)
      else $error("Enabled pin not low in stop with inhibit");

   property p_stop_oe;
      stop_mode |=> $stable(port_a_low_pins_oe);
   endproperty
   a_stop_oe: assert property (p_stop_oe)
      else $error("Pin enable moved in stop mode");

   property p_unsel_port;
      rstn && !st_ff.sel[2] && !stop_mode
         |=> (port_a_low_pins_out[2] == $past(gpio_out[2])) &&
             (port_a_low_pins_oe[2] == $past(gpio_oe[2]));
   endproperty
   a_unsel_port: assert property (p_unsel_port)
      else $error("Unselected pin does not follow the port");

   property p_pin_sample;
      rstn |=> (gpio_in == $past(port_a_low_pins_in));
   endproperty
   a_pin_sample: assert property (p_pin_sample)
      else $error("Port input is not the pin level one cycle late");
endmodule
`default_nettype wire

// *** tb/pwd_load.sv ***
// Purpose: Pin load with pull-downs; counts high clocks per window.
// Assumes: Window of 2048 clocks started by go, paused by hold.
// Notes:   Undriven pins read low, never the last driven value.
`default_nettype none
module pwd_load (
   // Clock
   input  wire logic        mclk,
   // Pins
   input  wire logic [3:0]  pin_out,
   input  wire logic [3:0]  pin_oe,
   output logic      [3:0]  lvl,
   // Measurement
   input  wire logic        go,
   input  wire logic        hold,
   output logic             done,
   output logic      [11:0] hi_cnt [4]
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] win = 12'd0;
   assign lvl = pin_oe & pin_out;
   always @(posedge mclk) begin
      done <= 1'b0;
      if (go) begin
         win <= 12'd2048;
         hi_cnt <= '{4{12'd0}};
      end else if (win != 12'd0 && !hold) begin
         win <= win - 12'd1;
         done <= (win == 12'd1);
         for (int i = 0; i < 4; i++) begin
            hi_cnt[i] <= hi_cnt[i] + {11'd0, lvl[i]};
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/test_four_channel_ten_bit_pwm_dac.sv ***
// Purpose: Self-checking bench for the PWM block.
// Assumes: 50 MHz clock, pull-down load on the pins.
// Notes:   Duty judged by high clocks in a 2048 clock window.
`default_nettype none
module test_four_channel_ten_bit_pwm_dac;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rstn, wr_en, rd_en, stop_mode, go, hold;
   logic        done, rd_seen, got;
   logic [7:0]  addr, wr_data, rd_data, rv;
   logic [3:0]  gpio_out, gpio_oe, gpio_in, p_out, p_oe, lvl;
   logic [11:0] hi_cnt [4];
   logic [15:0] t;
   logic [9:0]  d [4];
   logic [31:0] seed, r;
   int          error_cnt, checks_done, n, hc, ch;
   logic [15:0] rq [$];
   logic [11:0] dq [$];
   pwd_top u_dut (.mclk(mclk), .rstn(rstn), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .stop_mode(stop_mode),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
      .port_a_low_pins_in(lvl), .port_a_low_pins_out(p_out),
      .port_a_low_pins_oe(p_oe));
   pwd_load u_load (.mclk(mclk), .pin_out(p_out), .pin_oe(p_oe),
      .lvl(lvl), .go(go), .hold(hold), .done(done), .hi_cnt(hi_cnt));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic fail();
      error_cnt++;
      print_verdict();
   endtask
   task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_val(input logic [11:0] g, input logic [11:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
      @(posedge mclk);
   endtask
   // Mask zero means the read only feeds rv, no compare
   task automatic rd(input logic [7:0] a, e, m);
      rq.push_back({m, e});
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      @(negedge mclk);
      rv = rd_data;
      @(posedge mclk);
   endtask
   task automatic poll(input logic [7:0] v);
      rv = ~v;
      for (n = 0; n < 3000 && rv !== v; n++) rd(8'h2e, 8'h00, 8'h00);
      if (rv !== v) fail();
   endtask
   task automatic setd();
      for (int c = 0; c < 4; c++) begin
         wr(8'h25 + 8'(2 * c), d[c][9:2]);
         wr(8'h26 + 8'(2 * c), {6'h0, d[c][1:0]});
      end
   endtask
   task automatic watch(input int c, input logic [3:0] m,
                        output int h, output int k);
      logic [3:0] l0;
      h = 0;
      k = 0;
      @(negedge mclk);
      l0 = lvl;
      repeat (c) begin
         @(negedge mclk);
         h += int'(|(lvl & m));
         k += int'(lvl != l0);
      end
      @(posedge mclk);
   endtask
   // Stop freezes pins and the window together, so the count holds
   task automatic meas(input bit st);
      for (int i = 0; i < 4; i++) dq.push_back({1'b0, d[i], 1'b0});
      got = 1'b0;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      if (st) begin
         repeat (500) @(posedge mclk);
         stop_mode <= 1'b1;
         hold <= 1'b1;
         watch(300, 4'hf, hc, ch);
         chk_val(12'(ch), 12'h0);
         stop_mode <= 1'b0;
         hold <= 1'b0;
      end
      for (n = 0; n < 4000 && !got; n++) @(posedge mclk);
      if (!got) fail();
   endtask
   always @(posedge mclk) begin
      if (rd_seen && rq.size() > 0) begin
         t = rq.pop_front();
         if (t[15:8] != 8'h00) chk_rd(rd_data & t[15:8], t[7:0]);
      end
      rd_seen <= rd_en;
      if (done === 1'b1) begin
         for (int i = 0; i < 4; i++) chk_val(hi_cnt[i], dq.pop_front());
         got <= 1'b1;
      end
   end
   initial begin
      seed = 32'h06f0953e;
      {rstn, wr_en, rd_en, stop_mode, go, hold, rd_seen} = 7'h00;
      {addr, wr_data, gpio_out, gpio_oe} = 24'h0;
      error_cnt = 0;
      checks_done = 0;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      for (int a = 8'h25; a < 8'h2d; a++) rd(8'(a), 8'h00, 8'hff);
      rd(8'h2d, 8'h00, 8'hff);
      rd(8'h40, 8'h00, 8'hff);
      chk_val({8'h0, p_oe}, 12'h0);
      r = $random(seed);
      gpio_oe <= r[3:0];
      gpio_out <= r[7:4];
      repeat (3) @(posedge mclk);
      chk_val({8'h0, p_oe}, {8'h0, r[3:0]});
      chk_val({8'h0, gpio_in}, {8'h0, r[3:0] & r[7:4]});
      r = $random(seed);
      wr(8'h29, r[7:0]);
      wr(8'h2a, r[15:8]);
      wr(8'h28, r[23:16]);
      rd(8'h29, r[7:0], 8'hff);
      rd(8'h2a, {6'h0, r[9:8]}, 8'hff);
      rd(8'h28, {6'h0, r[17:16]}, 8'hff);
      $display("test registers done");
      d = '{10'h000, 10'h200, 10'h3ff, r[25:16]};
      setd();
      wr(8'h2d, 8'h0f);
      repeat (2100) @(posedge mclk);
      chk_val({8'h0, p_oe}, 12'h00f);
      meas(1'b0);
      $display("test duty done");
      d[0] = 10'h3ff;
      poll(8'h90);
      wr(8'h25, 8'hff);
      wr(8'h26, 8'h03);
      watch(500, 4'h1, hc, ch);
      chk_val(12'(hc), 12'h0);
      repeat (2100) @(posedge mclk);
      meas(1'b0);
      $display("test buffer done");
      poll(8'h40);
      wr(8'h2d, 8'h8f);
      repeat (300) @(posedge mclk);
      rd(8'h2e, 8'h40, 8'hfe);
      watch(50, 4'hf, hc, ch);
      chk_val(12'(hc), 12'h0);
      stop_mode <= 1'b1;
      watch(200, 4'hf, hc, ch);
      chk_val(12'(hc), 12'h0);
      chk_val({8'h0, p_oe}, 12'h00f);
      stop_mode <= 1'b0;
      wr(8'h2d, 8'h0f);
      meas(1'b1);
      $display("test inhibit and stop done");
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rd(8'h2d, 8'h00, 8'hff);
      poll(8'h02);
      chk_val({8'h0, p_oe}, {8'h0, gpio_oe});
      $display("test second reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
